// File: pkg/dual_comparator_params.svh
// register offsets, field positions, reset values for the dual comparator wrapper
// assumes classic wishbone byte addressing with one 32-bit word per register
`ifndef DUAL_COMPARATOR_PARAMS_SVH
`define DUAL_COMPARATOR_PARAMS_SVH

`define CMP_ADR_CTRL0_ONE   6'h00
`define CMP_ADR_CTRL1_ONE   6'h04
`define CMP_ADR_CTRL0_TWO   6'h08
`define CMP_ADR_CTRL1_TWO   6'h0c
`define CMP_ADR_MIRROR      6'h10
`define CMP_ADR_STATUS      6'h14
`define CMP_ADR_MASK        6'h18
`define CMP_ADR_PORT        6'h1c

`define CMP_BIT_ON          7
`define CMP_BIT_RESULT      6
`define CMP_BIT_PIN_OE      5
`define CMP_BIT_INVERT      4
`define CMP_BIT_SPEED       2
`define CMP_BIT_HYST        1
`define CMP_BIT_SYNC        0
`define CMP_BIT_RISE        7
`define CMP_BIT_FALL        6

`define CMP_CTRL0_WMASK     8'hb7
`define CMP_CTRL1_WMASK     8'hf3
`define CMP_CTRL0_RESET     8'h04
`define CMP_CTRL1_RESET     8'h00

`define CMP_PSEL_PIN        2'h0
`define CMP_PSEL_DAC        2'h1
`define CMP_PSEL_FIXED      2'h2
`define CMP_PSEL_ALT        2'h3

`endif

// File: pkg/dual_comparator_pkg.sv
// types shared by the dual comparator wrapper
// assumes the params header is included by the design files
package dual_comparator_pkg;

  typedef struct packed {
    logic       comparator_on;
    logic       pin_output_enable;
    logic       output_invert;
    logic       speed_power_select;
    logic       hysteresis_enable;
    logic       timer_sync_enable;
    logic       rise_event_enable;
    logic       fall_event_enable;
    logic [1:0] positive_input_select;
    logic [1:0] negative_input_select;
  } cmp_cfg_type;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ACK  = 3'b010,
    BUS_WAIT = 3'b100
  } bus_state_type;

endpackage

// File: design/comparator_channel.sv
// one comparator channel: result latch, edge detect, timer-synchronised output
// assumes raw analog decision and timer clock are already synchronised to clk_i
`timescale 1ns/100ps
module comparator_channel (
  input  wire logic                             clk_i,
  input  wire logic                             rst_i,
  input  wire dual_comparator_pkg::cmp_cfg_type cfg_i,
  input  wire logic                             raw_above_i,
  input  wire logic                             timer_clk_i,
  output logic                                  result_o,
  output logic                                  sync_result_o,
  output logic                                  edge_event_o
);

  logic result_ff;
  logic prev_result_ff;
  logic sync_result_ff;
  logic timer_clk_prev_ff;
  logic nxt_result;

  // ----------------------------------------
  // result latch
  // ----------------------------------------
  // disabled comparator decides low; invert still applies so toggling it makes an edge
  assign nxt_result = (raw_above_i & cfg_i.comparator_on) ^ cfg_i.output_invert; // [R2] [R15]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_ff <= 1'b0;
    end else begin
      result_ff <= nxt_result; // [R16]
    end
  end

  // ----------------------------------------
  // edge detect
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_result_ff <= 1'b0;
    end else begin
      prev_result_ff <= result_ff; // [R18]
    end
  end

  assign edge_event_o = (cfg_i.rise_event_enable & result_ff & ~prev_result_ff) | // [R7]
                        (cfg_i.fall_event_enable & ~result_ff & prev_result_ff);  // [R8]

  // ----------------------------------------
  // timer sync
  // ----------------------------------------
  // timer clock is the post-prescaler source; latch on its falling edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_clk_prev_ff <= 1'b0;
      sync_result_ff    <= 1'b0;
    end else begin
      timer_clk_prev_ff <= timer_clk_i;
      if (timer_clk_prev_ff && !timer_clk_i) begin
        sync_result_ff <= result_ff; // [R6] [R17]
      end
    end
  end

  assign result_o      = result_ff;
  assign sync_result_o = sync_result_ff;

endmodule

// File: design/dual_comparator_control.sv
// register wrapper for two analog comparators on classic wishbone
// assumes analog decisions, pins and timer clock come in asynchronously
// Overview of operation
// [R1] enable bit turns comparator on; clear means off and powered down; resets zero
// [R2] result reads one when noninverting above inverting, flipped by invert bit
// [R3] pin output enable routes result to pin, independent of enable bit
// [R4] speed select resets to one, normal power; zero selects low power
// [R5] hysteresis bit turns input hysteresis on when set; resets zero
// [R6] sync mode updates timer gate and pin result on timer clock falling edge
// [R7] rise enable lets rising result transitions set the event flag
// [R8] fall enable lets falling result transitions set the event flag
// [R9] positive select: pin, dac, fixed reference; code three pin or ground
// [R10] negative select routes one of four shared negative pins
// [R11] mirror register shows result two at bit one, result one at bit zero
// [R12] unimplemented bits read zero and ignore writes
// [R13] port read returns zero for every pin set as analog input
// [R14] software clears event flag; an edge during clearing keeps it set
// [R15] invert or enable toggles still raise edge events while disabled
// [R16] internal result latched every cycle; pin unlatched unless sync mode
// [R17] sync latch follows prescaler on falling edge, timer counts rising
// [R18] edges found by comparing latched result with previous cycle value
`timescale 1ns/100ps
`include "dual_comparator_params.svh"
module dual_comparator_control #(
  parameter int PORT_WIDTH = 8
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [5:0]            adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  output logic                       irq_o,
  input  wire logic [1:0]            raw_above_i,
  input  wire logic                  timer_clk_i,
  input  wire logic [PORT_WIDTH-1:0] port_pins_i,
  input  wire logic [PORT_WIDTH-1:0] analog_select_i,
  output logic      [1:0]            comparator_on_o,
  output logic      [1:0]            speed_power_select_o,
  output logic      [1:0]            hysteresis_enable_o,
  output logic      [3:0]            positive_route_o,
  output logic      [3:0]            negative_route_o,
  output logic      [1:0]            result_pin_o,
  output logic      [1:0]            pin_output_enable_o,
  output logic      [1:0]            timer_gate_o
);

  initial begin
    if (PORT_WIDTH < 1 || PORT_WIDTH > 32) begin
      $error("PORT_WIDTH must be 1 to 32");
    end
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [1:0]            raw_meta_ff;
  logic [1:0]            raw_sync_ff;
  logic                  tclk_meta_ff;
  logic                  tclk_sync_ff;
  logic [PORT_WIDTH-1:0] port_meta_ff;
  logic [PORT_WIDTH-1:0] port_sync_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw_meta_ff  <= 2'h0;
      raw_sync_ff  <= 2'h0;
      tclk_meta_ff <= 1'b0;
      tclk_sync_ff <= 1'b0;
      port_meta_ff <= '0;
      port_sync_ff <= '0;
    end else begin
      raw_meta_ff  <= raw_above_i;
      raw_sync_ff  <= raw_meta_ff;
      tclk_meta_ff <= timer_clk_i;
      tclk_sync_ff <= tclk_meta_ff;
      port_meta_ff <= port_pins_i;
      port_sync_ff <= port_meta_ff;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic [7:0]                       ctrl0_ff [2];
  logic [7:0]                       ctrl1_ff [2];
  logic [1:0]                       status_ff;
  logic [1:0]                       mask_ff;
  dual_comparator_pkg::cmp_cfg_type cfg [2];
  logic [1:0]                       result;
  logic [1:0]                       sync_result;
  logic [1:0]                       edge_event;
  logic                             wr_take;
  logic                             rd_take;
  dual_comparator_pkg::bus_state_type bus_state_ff;

  assign wr_take = (bus_state_ff == dual_comparator_pkg::BUS_IDLE) & cyc_i & stb_i & we_i &
                   sel_i[0];
  assign rd_take = (bus_state_ff == dual_comparator_pkg::BUS_IDLE) & cyc_i & stb_i & ~we_i;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_chan
      localparam logic [5:0] ADR0 = (g == 0) ? `CMP_ADR_CTRL0_ONE : `CMP_ADR_CTRL0_TWO;
      localparam logic [5:0] ADR1 = (g == 0) ? `CMP_ADR_CTRL1_ONE : `CMP_ADR_CTRL1_TWO;

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ctrl0_ff[g] <= `CMP_CTRL0_RESET; // [R1] [R4] [R5]
          ctrl1_ff[g] <= `CMP_CTRL1_RESET;
        end else if (wr_take) begin
          if (adr_i == ADR0) begin
            ctrl0_ff[g] <= dat_i[7:0] & `CMP_CTRL0_WMASK; // [R12]
          end
          if (adr_i == ADR1) begin
            ctrl1_ff[g] <= dat_i[7:0] & `CMP_CTRL1_WMASK; // [R12]
          end
        end
      end

      assign cfg[g].comparator_on         = ctrl0_ff[g][`CMP_BIT_ON];
      assign cfg[g].pin_output_enable     = ctrl0_ff[g][`CMP_BIT_PIN_OE];
      assign cfg[g].output_invert         = ctrl0_ff[g][`CMP_BIT_INVERT];
      assign cfg[g].speed_power_select    = ctrl0_ff[g][`CMP_BIT_SPEED];
      assign cfg[g].hysteresis_enable     = ctrl0_ff[g][`CMP_BIT_HYST];
      assign cfg[g].timer_sync_enable     = ctrl0_ff[g][`CMP_BIT_SYNC];
      assign cfg[g].rise_event_enable     = ctrl1_ff[g][`CMP_BIT_RISE];
      assign cfg[g].fall_event_enable     = ctrl1_ff[g][`CMP_BIT_FALL];
      assign cfg[g].positive_input_select = ctrl1_ff[g][5:4];
      assign cfg[g].negative_input_select = ctrl1_ff[g][1:0];

      comparator_channel u_chan (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .cfg_i         (cfg[g]),
        .raw_above_i   (raw_sync_ff[g]),
        .timer_clk_i   (tclk_sync_ff),
        .result_o      (result[g]),
        .sync_result_o (sync_result[g]),
        .edge_event_o  (edge_event[g])
      );

      // ----------------------------------------
      // analog and pin outputs
      // ----------------------------------------
      logic       pin_val;
      logic [1:0] pos_route;
      // code three on channel two selects ground, encoded as route 3
      assign pos_route = cfg[g].positive_input_select; // [R9]
      assign pin_val   = cfg[g].timer_sync_enable ? sync_result[g] : result[g]; // [R6] [R16]

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          comparator_on_o[g]      <= 1'b0;
          speed_power_select_o[g] <= 1'b1;
          hysteresis_enable_o[g]  <= 1'b0;
          positive_route_o[2*g+1:2*g] <= 2'h0;
          negative_route_o[2*g+1:2*g] <= 2'h0;
          result_pin_o[g]         <= 1'b0;
          pin_output_enable_o[g]  <= 1'b0;
          timer_gate_o[g]         <= 1'b0;
        end else begin
          comparator_on_o[g]      <= cfg[g].comparator_on; // [R1]
          speed_power_select_o[g] <= cfg[g].speed_power_select; // [R4]
          hysteresis_enable_o[g]  <= cfg[g].hysteresis_enable; // [R5]
          if (g == 0 && pos_route == `CMP_PSEL_ALT) begin
            positive_route_o[2*g+1:2*g] <= `CMP_PSEL_PIN; // [R9]
          end else begin
            positive_route_o[2*g+1:2*g] <= pos_route; // [R9]
          end
          negative_route_o[2*g+1:2*g] <= cfg[g].negative_input_select; // [R10]
          result_pin_o[g]         <= pin_val; // [R3]
          pin_output_enable_o[g]  <= cfg[g].pin_output_enable; // [R3]
          timer_gate_o[g]         <= pin_val; // [R6]
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // event flags and interrupt
  // ----------------------------------------
  logic [1:0] clr_bits;
  assign clr_bits = (wr_take && adr_i == `CMP_ADR_STATUS) ? dat_i[1:0] : 2'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_ff <= 2'h0;
    end else begin
      // set beats clear so an edge during the clear write is kept
      status_ff <= (status_ff & ~clr_bits) | edge_event; // [R14]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_ff <= 2'h0;
    end else if (wr_take && adr_i == `CMP_ADR_MASK) begin
      mask_ff <= dat_i[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_ff & mask_ff);
    end
  end

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  logic [7:0]  ctrl0_read [2];
  logic [31:0] nxt_dat;
  logic [PORT_WIDTH-1:0] port_read;

  assign ctrl0_read[0] = ctrl0_ff[0] | {1'b0, result[0], 6'h00}; // [R2]
  assign ctrl0_read[1] = ctrl0_ff[1] | {1'b0, result[1], 6'h00}; // [R2]
  assign port_read     = port_sync_ff & ~analog_select_i; // [R13]

  always_comb begin
    nxt_dat = 32'h0000_0000;
    unique case (adr_i)
      `CMP_ADR_CTRL0_ONE: nxt_dat[7:0] = ctrl0_read[0];
      `CMP_ADR_CTRL1_ONE: nxt_dat[7:0] = ctrl1_ff[0];
      `CMP_ADR_CTRL0_TWO: nxt_dat[7:0] = ctrl0_read[1];
      `CMP_ADR_CTRL1_TWO: nxt_dat[7:0] = ctrl1_ff[1];
      `CMP_ADR_MIRROR:    nxt_dat[1:0] = {result[1], result[0]}; // [R11] [R12]
      `CMP_ADR_STATUS:    nxt_dat[1:0] = status_ff;
      `CMP_ADR_MASK:      nxt_dat[1:0] = mask_ff;
      `CMP_ADR_PORT:      nxt_dat[PORT_WIDTH-1:0] = port_read;
      default:            nxt_dat = 32'h0000_0000;
    endcase
  end

  // one registered ack a cycle after the request is seen, then wait until cyc_i or stb_i drops so a held request is not taken twice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state_ff <= dual_comparator_pkg::BUS_IDLE;
      ack_o        <= 1'b0;
      dat_o        <= 32'h0000_0000;
    end else begin
      unique case (bus_state_ff)
        dual_comparator_pkg::BUS_IDLE: begin
          ack_o <= 1'b0;
          if (cyc_i && stb_i) begin
            bus_state_ff <= dual_comparator_pkg::BUS_ACK;
            ack_o        <= 1'b1;
            dat_o        <= rd_take ? nxt_dat : 32'h0000_0000;
          end
        end
        dual_comparator_pkg::BUS_ACK: begin
          ack_o        <= 1'b0;
          dat_o        <= 32'h0000_0000;
          bus_state_ff <= dual_comparator_pkg::BUS_WAIT;
        end
        dual_comparator_pkg::BUS_WAIT: begin
          ack_o <= 1'b0;
          if (!(cyc_i && stb_i)) begin
            bus_state_ff <= dual_comparator_pkg::BUS_IDLE;
          end
        end
        default: begin
          ack_o        <= 1'b0;
          bus_state_ff <= dual_comparator_pkg::BUS_IDLE;
        end
      endcase
    end
  end

endmodule

// File: tb/dual_comparator_control_props.sv
// bus, reset and output relations of the dual comparator wrapper
// sees only the top ports; bound in from the bench top file
`timescale 1ns/100ps
`include "dual_comparator_params.svh"
module dual_comparator_control_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [5:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        irq_o,
  input wire logic [1:0]  comparator_on_o,
  input wire logic [1:0]  speed_power_select_o,
  input wire logic [3:0]  positive_route_o,
  input wire logic [1:0]  result_pin_o,
  input wire logic [1:0]  pin_output_enable_o,
  input wire logic [1:0]  timer_gate_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // write accepted at the ack edge
  // ----------------------------------------
  sequence bus_write(a);
    ack_o && we_i && sel_i[0] && adr_i == a;
  endsequence
  ack_after_req_a: assert property ($rose(cyc_i && stb_i) |=> ack_o)
    else $error("no ack one cycle after request");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  dat_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  reset_vals_a: assert property ($fell(rst_i) |->
    speed_power_select_o == 2'b11 && comparator_on_o == 2'b00)
    else $error("wrong control outputs after reset");
  on_write_a: assert property (bus_write(`CMP_ADR_CTRL0_ONE) |=>
    comparator_on_o[0] == $past(dat_i[`CMP_BIT_ON]))
    else $error("enable output not following write");
  oe_write_a: assert property (bus_write(`CMP_ADR_CTRL0_TWO) |=>
    pin_output_enable_o[1] == $past(dat_i[`CMP_BIT_PIN_OE]))
    else $error("pin enable output not following write");
  irq_masked_a: assert property (bus_write(`CMP_ADR_MASK) ##0 dat_i[1:0] == 2'b00
    |=> ##1 !irq_o)
    else $error("interrupt high with everything masked");
  no_ground_a: assert property (positive_route_o[1:0] != 2'h3)
    else $error("channel one routed to ground");
  gate_pin_a: assert property (timer_gate_o == result_pin_o)
    else $error("timer gate differs from pin result");
endmodule

// File: tb/analog_front_model.sv
// analog pins, references and timer clock facing the comparators
// levels are set by the bench through hierarchical names
`timescale 1ns/100ps
module analog_front_model (
  input  wire logic [3:0] positive_route_i,
  input  wire logic [3:0] negative_route_i,
  output logic      [1:0] raw_above_o,
  output logic            timer_clk_o,
  output logic      [7:0] port_pins_o
);
  int         pos_mv [2];
  int         neg_mv [4] = '{100, 300, 500, 700};
  int         dac_mv     = 800;
  int         fixed_mv   = 200;
  int         vp     [2];
  logic       timer_lvl  = 1'b0;
  logic [7:0] pins       = 8'h00;
  // ideal comparator, no offset or response time
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      case (positive_route_i[2*c +: 2])
        2'h1:    vp[c] = dac_mv;
        2'h2:    vp[c] = fixed_mv;
        2'h3:    vp[c] = 0;
        default: vp[c] = pos_mv[c];
      endcase
      raw_above_o[c] = vp[c] > neg_mv[negative_route_i[2*c +: 2]];
    end
  end
  assign timer_clk_o = timer_lvl;
  assign port_pins_o = pins;
endmodule

// File: tb/tb_dual_comparator_control.sv
// self-checking bench for the dual comparator wrapper
// drives wishbone directly; analog side comes from the front model
`timescale 1ns/100ps
`include "dual_comparator_params.svh"
module tb_dual_comparator_control;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, timer_clk_i;
  logic [5:0]  adr_i;
  logic [3:0]  sel_i, positive_route_o, negative_route_o;
  logic [31:0] dat_i, dat_o;
  logic [1:0]  raw_above_i, comparator_on_o, speed_power_select_o, hysteresis_enable_o;
  logic [1:0]  result_pin_o, pin_output_enable_o, timer_gate_o;
  logic [7:0]  port_pins_i, analog_select_i, rd;
  int          fail_count, checks;
  dual_comparator_control i_dut (.*);
  analog_front_model i_afe (.positive_route_i(positive_route_o),
    .negative_route_i(negative_route_o), .raw_above_o(raw_above_i),
    .timer_clk_o(timer_clk_i), .port_pins_o(port_pins_i));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wb(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o[7:0];
    chk({7'h0, ack_o}, 8'h01);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask
  task rdchk(input logic [5:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task setp(input int mv);
    @(posedge clk_i);
    i_afe.pos_mv[0] <= mv;
  endtask
  task tmr(input logic v);
    @(posedge clk_i);
    i_afe.timer_lvl <= v;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    chk({6'h0, speed_power_select_o}, 8'h03);
    rdchk(`CMP_ADR_CTRL0_ONE, 8'h04);
    rdchk(`CMP_ADR_CTRL1_TWO, 8'h00);
    rdchk(`CMP_ADR_MIRROR, 8'h00);
  endtask
  task t_unimpl;
    wb(1'b1, `CMP_ADR_CTRL1_ONE, 8'hff);
    rdchk(`CMP_ADR_CTRL1_ONE, 8'hf3);
    wb(1'b1, `CMP_ADR_CTRL0_TWO, 8'h0a);
    rdchk(`CMP_ADR_CTRL0_TWO, 8'h02);
    chk({6'h0, hysteresis_enable_o}, 8'h02);
    chk({6'h0, speed_power_select_o}, 8'h01);
    wb(1'b1, `CMP_ADR_MIRROR, 8'hff);
    rdchk(`CMP_ADR_MIRROR, 8'h00);
    wb(1'b1, 6'h20, 8'hff);
    rdchk(6'h20, 8'h00);
    @(posedge clk_i);
    sel_i <= 4'he;
    wb(1'b1, `CMP_ADR_CTRL1_ONE, 8'h00);
    sel_i <= 4'hf;
    rdchk(`CMP_ADR_CTRL1_ONE, 8'hf3);
    wb(1'b1, `CMP_ADR_CTRL1_ONE, 8'h00);
    wb(1'b1, `CMP_ADR_CTRL0_TWO, 8'h04);
  endtask
  task t_select;
    logic       c, e;
    logic [1:0] p, n;
    logic [5:0] b;
    logic [5:0] t [9];
    t = '{6'h05, 6'h0f, 6'h11, 6'h12, 6'h1e, 6'h1d, 6'h38, 6'h26, 6'h2f};
    setp(600);
    i_afe.pos_mv[1] = 600;
    for (int i = 0; i < 9; i++) begin
      {c, p, n, e} = t[i];
      b = c ? `CMP_ADR_CTRL0_TWO : `CMP_ADR_CTRL0_ONE;
      wb(1'b1, b + 6'h04, {2'b00, p, 2'b00, n});
      wb(1'b1, b, 8'h84);
      idle(6);
      rdchk(b, {1'b1, e, 6'h04});
      rdchk(`CMP_ADR_MIRROR, {7'h0, e} << c);
      chk({6'h0, c ? positive_route_o[3:2] : positive_route_o[1:0]},
          {6'h0, (p == 2'h3 && !c) ? 2'h0 : p});
      chk({6'h0, c ? negative_route_o[3:2] : negative_route_o[1:0]}, {6'h0, n});
      wb(1'b1, b, 8'h94);
      idle(6);
      rdchk(b, {1'b1, !e, 6'h14});
      wb(1'b1, b, 8'h04);
    end
  endtask
  task t_events;
    setp(0);
    wb(1'b1, `CMP_ADR_CTRL1_ONE, 8'h80);
    wb(1'b1, `CMP_ADR_CTRL0_ONE, 8'h84);
    idle(8);
    wb(1'b1, `CMP_ADR_STATUS, 8'h03);
    wb(1'b1, `CMP_ADR_MASK, 8'h01);
    setp(600);
    idle(8);
    rdchk(`CMP_ADR_STATUS, 8'h01);
    chk({7'h0, irq_o}, 8'h01);
    wb(1'b1, `CMP_ADR_STATUS, 8'h01);
    idle(2);
    rdchk(`CMP_ADR_STATUS, 8'h00);
    chk({7'h0, irq_o}, 8'h00);
    setp(0);
    idle(8);
    rdchk(`CMP_ADR_STATUS, 8'h00);
    wb(1'b1, `CMP_ADR_CTRL1_ONE, 8'h40);
    setp(600);
    idle(8);
    rdchk(`CMP_ADR_STATUS, 8'h00);
    setp(0);
    idle(8);
    rdchk(`CMP_ADR_STATUS, 8'h01);
    wb(1'b1, `CMP_ADR_MASK, 8'h00);
    idle(2);
    chk({7'h0, irq_o}, 8'h00);
    wb(1'b1, `CMP_ADR_CTRL0_ONE, 8'h04);
    wb(1'b1, `CMP_ADR_CTRL1_ONE, 8'h80);
    wb(1'b1, `CMP_ADR_STATUS, 8'h01);
    wb(1'b1, `CMP_ADR_CTRL0_ONE, 8'h14);
    idle(8);
    rdchk(`CMP_ADR_STATUS, 8'h01);
  endtask
  task t_pin;
    wb(1'b1, `CMP_ADR_CTRL0_ONE, 8'h04);
    wb(1'b1, `CMP_ADR_CTRL0_TWO, 8'h34);
    idle(6);
    chk({6'h0, pin_output_enable_o}, 8'h02);
    chk({6'h0, result_pin_o}, 8'h02);
    tmr(1'b1);
    idle(4);
    tmr(1'b0);
    idle(4);
    tmr(1'b1);
    wb(1'b1, `CMP_ADR_CTRL0_TWO, 8'h35);
    wb(1'b1, `CMP_ADR_CTRL0_TWO, 8'h25);
    idle(8);
    chk({6'h0, result_pin_o}, 8'h02);
    tmr(1'b0);
    idle(6);
    chk({6'h0, result_pin_o}, 8'h00);
    wb(1'b1, `CMP_ADR_CTRL0_TWO, 8'h35);
    tmr(1'b1);
    idle(6);
    chk({6'h0, result_pin_o}, 8'h00);
    tmr(1'b0);
    idle(6);
    chk({6'h0, result_pin_o}, 8'h02);
    wb(1'b1, `CMP_ADR_CTRL0_TWO, 8'h04);
    idle(2);
    chk({6'h0, pin_output_enable_o}, 8'h00);
  endtask
  task t_port;
    @(posedge clk_i);
    i_afe.pins      <= 8'hff;
    analog_select_i <= 8'h5a;
    idle(6);
    rdchk(`CMP_ADR_PORT, 8'ha5);
  endtask
  task report_and_stop;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // whole run is under a thousand cycles; this limit of 40000 cycles is generous
  initial begin
    #1000000;
    fail_count++;
    report_and_stop;
  end
  initial begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i} = 3'b000;
    adr_i = 6'h00;
    sel_i = 4'hf;
    dat_i = 32'h0;
    analog_select_i = 8'h00;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_unimpl;
    t_select;
    t_events;
    t_pin;
    t_port;
    report_and_stop;
  end
endmodule
bind dual_comparator_control dual_comparator_control_props i_props (.*);
